// File: core/ibpe_defines.svh
// constants for the two-wire bus protocol engine
`ifndef IBPE_DEFINES_SVH
`define IBPE_DEFINES_SVH
`define IBPE_HDR10        5'h1e
`define IBPE_BYTE_BITS    4'h8
`define IBPE_LEN_FULL     3'h0
`define IBPE_QTR_DEFAULT  8'h19
`define IBPE_ZERO8        8'h00
`define IBPE_ZERO4        4'h0
`endif

// File: core/ibpe_pkg.sv
// types shared by the two-wire bus protocol engine
package ibpe_pkg;
   typedef enum logic [3:0]
   {
      M_IDLE  = 4'h0,
      M_START = 4'h1,
      M_LOW   = 4'h2,
      M_HIGH  = 4'h3,
      M_P1    = 4'h4,
      M_P2    = 4'h5,
      M_P3    = 4'h6,
      M_R1    = 4'h7,
      M_R2    = 4'h8
   } ibpe_mstate_e;

   typedef enum logic [1:0]
   {
      PH_ADDR1 = 2'h0,
      PH_ADDR2 = 2'h1,
      PH_DATA  = 2'h2
   } ibpe_phase_e;
endpackage

// File: core/ibpe_sync.sv
// two-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module ibpe_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_in,
   input  wire logic         rst_n_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta;

   // the first stage feeds only the second
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         meta  <= '0;
         q_out <= '0;
      end
      else
      begin
         meta  <= d_in;
         q_out <= meta;
      end
   end
endmodule

// File: core/ibpe_engine.sv
// two-wire bus protocol engine: start/stop, addressing, word shifting, clock stretching
//
// Overview of operation
// RL1: sda and scl are only pulled low or released, never driven high.
// RL2: bus idle when both lines high; lines released whenever not pulled low.
// RL3: master makes exactly one scl pulse per address, data or acknowledge bit.
// RL4: sda changes only while scl is low, stable while scl is high.
// RL5: master start is sda falling while scl stays high.
// RL6: master stop is sda rising while scl stays high.
// RL7: bus-busy flag set on any start, cleared on any stop.
// RL8: start only when master select and start request are both set.
// RL9: stop request ends a master transfer with a stop.
// RL10: start request while bus busy gives a repeated start.
// RL11: words are 1 to 8 bits; field value 000 means eight bits.
// RL12: address and data words go out most significant bit first.
// RL13: 7-bit mode first byte is address plus direction; 1 means master reads.
// RL14: acknowledge clock after address and after each word, from the receiver.
// RL15: 10-bit mode sends header 11110, two top bits, write; then low byte.
// RL16: after 10-bit address master writes data or restarts to turn direction.
// RL17: free format sends words right after start, no address, fixed direction.
// RL18: repeated start allowed after any word; any number of words.
// RL19: master begins transmitting; receives only after address with read bit.
// RL20: slave begins receiving; transmits only on own address with read bit.
// RL21: slave makes no clock; holds scl low while host service pending.
// RL22: master holds scl low while rx unread or tx data missing.
// RL23: field values 001 to 111 give that many bits per word.
// RL24: first start only on idle bus; otherwise wait for the stop.
`timescale 1ns/1ps
`include "ibpe_defines.svh"
module ibpe_engine #(
   parameter logic [7:0] QTR = `IBPE_QTR_DEFAULT
) (
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   input  wire logic       module_clk_in,
   input  wire logic       master_select_in,
   input  wire logic       start_request_in,
   input  wire logic       stop_request_in,
   input  wire logic [2:0] word_length_field_in,
   input  wire logic       extended_address_select_in,
   input  wire logic       free_format_select_in,
   input  wire logic       read_dir_in,
   input  wire logic [9:0] slave_address_in,
   input  wire logic [9:0] own_address_in,
   input  wire logic [7:0] tx_data_in,
   input  wire logic       tx_write_in,
   input  wire logic       rx_read_in,
   input  wire logic       sda_in,
   input  wire logic       scl_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   output logic            scl_out,
   output logic            scl_oe_out,
   output logic            bus_busy_flag_out,
   output logic            receive_shift_full_out,
   output logic            transmit_shift_empty_n_out,
   output logic [7:0]      rx_data_out,
   output logic            master_mode_out,
   output logic            transmitter_mode_out
);
   localparam logic [7:0] HALF = 8'(2 * QTR - 1);

   // effective word length: zero field selects a full byte
   function automatic logic [3:0] word_len(input logic [2:0] f);
      word_len = (f == `IBPE_LEN_FULL) ? `IBPE_BYTE_BITS : {1'b0, f}; // RL11 RL23
   endfunction

   // left-align a short word so its top bit leaves first
   function automatic logic [7:0] align_msb(input logic [7:0] d, input logic [3:0] n);
      align_msb = 8'(d << (`IBPE_BYTE_BITS - n)); // RL12
   endfunction

   // ****************************************************************
   // host domain
   // ****************************************************************
   logic       start_pend;
   logic       stop_pend;
   logic [7:0] tx_word;
   logic       rd_t;
   logic [6:0] h_q;
   logic [6:0] h_prev;
   logic [6:0] h_edge;
   logic       bb_l;
   logic       start_ack_t;
   logic       stop_ack_t;
   logic       take_t;
   logic       put_t;
   logic       mst_act;
   logic       dir_tx;
   logic [7:0] rx_hold;

   ibpe_sync #(.W(7)) u_hsync (
      .clk_in   (ref_clk_in),
      .rst_n_in (resetn_in),
      .d_in     ({dir_tx, mst_act, put_t, take_t, stop_ack_t, start_ack_t, bb_l}),
      .q_out    (h_q)
   );
   assign h_edge = h_q ^ h_prev;
   assign bus_busy_flag_out = h_q[0];
   assign master_mode_out = h_q[5];
   assign transmitter_mode_out = h_q[6];

   // requests stay pending until the link echoes them; a new request wins
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         h_prev     <= '0;
         start_pend <= 1'b0;
         stop_pend  <= 1'b0;
      end
      else
      begin
         h_prev <= h_q;
         if (start_request_in)
            start_pend <= 1'b1;
         else if (h_edge[1])
            start_pend <= 1'b0;
         if (stop_request_in)
            stop_pend <= 1'b1;
         else if (h_edge[2])
            stop_pend <= 1'b0;
      end
   end

   // transmit holding word: written only when empty, so it is stable when the link reads it
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         tx_word                    <= `IBPE_ZERO8;
         transmit_shift_empty_n_out <= 1'b0;
      end
      else if (tx_write_in && !transmit_shift_empty_n_out)
      begin
         tx_word                    <= tx_data_in;
         transmit_shift_empty_n_out <= 1'b1;
      end
      else if (h_edge[3])
         transmit_shift_empty_n_out <= 1'b0;
   end

   // receive word: new data sets the flag ahead of a same-cycle read
   always_ff @(posedge ref_clk_in)
   begin
      if (!resetn_in)
      begin
         rx_data_out            <= `IBPE_ZERO8;
         receive_shift_full_out <= 1'b0;
         rd_t                   <= 1'b0;
      end
      else
      begin
         if (h_edge[4])
         begin
            rx_data_out            <= rx_hold;
            receive_shift_full_out <= 1'b1;
         end
         else if (rx_read_in && receive_shift_full_out)
            receive_shift_full_out <= 1'b0;
         if (rx_read_in && receive_shift_full_out)
            rd_t <= ~rd_t;
      end
   end

   // ****************************************************************
   // link domain
   // ****************************************************************
   logic        lrst_meta;
   logic        lrst_n;
   logic [32:0] l_q;
   logic        sda_s, scl_s, sda_p, scl_p, rd_p;
   logic        stt_s, stp_s, txf_s, rd_s, ms_s, xa_s, fdf_s, rdir_s;
   logic [2:0]  wl_s;
   logic [9:0]  sa_s, own_s;

   // reset reaches the link clock through two flops
   always_ff @(posedge module_clk_in)
   begin
      lrst_meta <= resetn_in;
      lrst_n    <= lrst_meta;
   end

   // pins and quasi-static settings; settings must not move during a transfer
   ibpe_sync #(.W(33)) u_lsync (
      .clk_in   (module_clk_in),
      .rst_n_in (lrst_n),
      .d_in     ({sda_in, scl_in, rd_t, transmit_shift_empty_n_out, stop_pend, start_pend,
                  master_select_in, extended_address_select_in, free_format_select_in,
                  read_dir_in, word_length_field_in, slave_address_in, own_address_in}),
      .q_out    (l_q)
   );
   assign {sda_s, scl_s, rd_s, txf_s, stp_s, stt_s, ms_s, xa_s, fdf_s, rdir_s, wl_s, sa_s,
           own_s} = l_q;

   ibpe_pkg::ibpe_mstate_e state;
   ibpe_pkg::ibpe_phase_e  phase;
   logic [7:0] cnt;
   logic [7:0] sh;
   logic [7:0] next_sh;
   logic [7:0] rx_byte;
   logic [3:0] bitn;
   logic       in_ack, slv_act, slv_pend, addr_ok, hdr_rw, rs_mode, scl_m;
   logic       take_wait, stt_wait, stp_wait, rx_pend;
   logic       start_det, stop_det, rise, fall, wb, stall, tx_ok, stop_ok, rs_ok;
   logic       m_slot, m_to_stop, m_to_rs, m_go_start, m_start_done, m_p2_end, m_r2_end;
   logic       slot_go, sample, cur_tx, ack_drv, hi_end;

   // line events from the synchronised pins
   assign start_det = scl_s && scl_p && sda_p && !sda_s;  // RL5
   assign stop_det  = scl_s && scl_p && !sda_p && sda_s;  // RL6
   assign rise      = scl_s && !scl_p;
   assign fall      = !scl_s && scl_p;

   // word boundary and host-service stall
   assign wb      = (bitn == `IBPE_ZERO4) && !in_ack;
   assign tx_ok   = txf_s && !take_wait;
   assign stall   = wb && (phase == ibpe_pkg::PH_DATA) && (dir_tx ? !tx_ok : rx_pend); // RL21 RL22
   assign stop_ok = stp_s && !stp_wait;
   assign rs_ok   = stt_s && !stt_wait && ms_s;

   // master sequencing events
   assign hi_end       = scl_s && (cnt == HALF);
   assign m_slot       = (state == ibpe_pkg::M_LOW) && (cnt == QTR);
   assign m_to_stop    = m_slot && wb && stop_ok;            // RL9
   assign m_to_rs      = m_slot && wb && !stop_ok && rs_ok;  // RL10 RL16 RL18
   assign m_go_start   = (state == ibpe_pkg::M_IDLE) && ms_s && stt_s && !stt_wait && !bb_l &&
                         sda_s && scl_s;                     // RL8 RL24 RL2
   assign m_start_done = (state == ibpe_pkg::M_START) && (cnt == HALF);
   assign m_p2_end     = (state == ibpe_pkg::M_P2) && hi_end;
   assign m_r2_end     = (state == ibpe_pkg::M_R2) && hi_end;
   assign slot_go      = ((m_slot && !m_to_stop && !m_to_rs) || slv_pend) && !stall;
   assign sample       = ((state == ibpe_pkg::M_HIGH) && hi_end) || (slv_act && rise);
   assign rx_byte      = {sh[6:0], sda_s};

   // word loaded at a boundary slot, otherwise the shifter holds
   always_comb
   begin
      next_sh = sh;
      if (wb && phase == ibpe_pkg::PH_ADDR2)
         next_sh = mst_act ? sa_s[7:0] : `IBPE_ZERO8; // RL15
      else if (wb && dir_tx)
         next_sh = align_msb(tx_word, word_len(wl_s));
      else if (wb)
         next_sh = `IBPE_ZERO8;
   end
   assign cur_tx  = (phase == ibpe_pkg::PH_DATA) ? dir_tx : mst_act;
   assign ack_drv = !cur_tx && (mst_act || phase == ibpe_pkg::PH_DATA || addr_ok); // RL14

   // pin edge history and bus busy flag
   always_ff @(posedge module_clk_in)
   begin
      if (!lrst_n)
      begin
         sda_p <= 1'b1;
         scl_p <= 1'b1;
         bb_l  <= 1'b0;
      end
      else
      begin
         sda_p <= sda_s;
         scl_p <= scl_s;
         if (start_det)
            bb_l <= 1'b1; // RL7
         else if (stop_det)
            bb_l <= 1'b0; // RL7
      end
   end

   // master clock generator; each bit is one low and one high half
   always_ff @(posedge module_clk_in)
   begin
      if (!lrst_n)
      begin
         state   <= ibpe_pkg::M_IDLE;
         cnt     <= `IBPE_ZERO8;
         scl_m   <= 1'b0;
         mst_act <= 1'b0;
         rs_mode <= 1'b0;
      end
      else
      begin
         case (state)
            ibpe_pkg::M_IDLE:
            begin
               cnt <= `IBPE_ZERO8;
               if (m_go_start)
               begin
                  state   <= ibpe_pkg::M_START;
                  mst_act <= 1'b1;
                  rs_mode <= 1'b0;
               end
            end
            ibpe_pkg::M_START, ibpe_pkg::M_P1, ibpe_pkg::M_R1, ibpe_pkg::M_P3:
            begin
               cnt <= 8'(cnt + 8'h01);
               if (cnt == HALF)
               begin
                  cnt <= `IBPE_ZERO8;
                  case (state)
                     ibpe_pkg::M_START: state <= ibpe_pkg::M_LOW;
                     ibpe_pkg::M_P1:    state <= ibpe_pkg::M_P2;
                     ibpe_pkg::M_R1:    state <= ibpe_pkg::M_R2;
                     default:           state <= ibpe_pkg::M_IDLE;
                  endcase
                  scl_m <= (state == ibpe_pkg::M_START);
                  if (state == ibpe_pkg::M_P3)
                     mst_act <= 1'b0;
               end
            end
            ibpe_pkg::M_LOW:
            begin
               if (m_to_stop || m_to_rs)
               begin
                  state <= m_to_stop ? ibpe_pkg::M_P1 : ibpe_pkg::M_R1;
                  cnt   <= `IBPE_ZERO8;
               end
               else if (m_slot && stall)
                  cnt <= cnt; // RL22
               else if (cnt == HALF)
               begin
                  state <= ibpe_pkg::M_HIGH;
                  scl_m <= 1'b0;
                  cnt   <= `IBPE_ZERO8;
               end
               else
                  cnt <= 8'(cnt + 8'h01);
            end
            ibpe_pkg::M_HIGH, ibpe_pkg::M_P2, ibpe_pkg::M_R2:
            begin
               // a slave holding scl low restarts the high count
               if (!scl_s)
                  cnt <= `IBPE_ZERO8;
               else if (cnt == HALF)
               begin
                  cnt <= `IBPE_ZERO8;
                  case (state)
                     ibpe_pkg::M_HIGH: state <= ibpe_pkg::M_LOW;
                     ibpe_pkg::M_P2:   state <= ibpe_pkg::M_P3;
                     default:          state <= ibpe_pkg::M_START;
                  endcase
                  scl_m <= (state == ibpe_pkg::M_HIGH); // RL3
                  if (state == ibpe_pkg::M_R2)
                     rs_mode <= 1'b1;
               end
               else
                  cnt <= 8'(cnt + 8'h01);
            end
            default:
            begin
               state <= ibpe_pkg::M_IDLE;
               scl_m <= 1'b0;
            end
         endcase
      end
   end

   // word sequencer: phases, shifter, bit count, acknowledge slot
   always_ff @(posedge module_clk_in)
   begin
      if (!lrst_n)
      begin
         phase   <= ibpe_pkg::PH_ADDR1;
         sh      <= `IBPE_ZERO8;
         bitn    <= `IBPE_ZERO4;
         in_ack  <= 1'b0;
         dir_tx  <= 1'b0;
         slv_act <= 1'b0;
         addr_ok <= 1'b0;
         hdr_rw  <= 1'b0;
      end
      else if (m_start_done)
      begin
         phase  <= fdf_s ? ibpe_pkg::PH_DATA : ibpe_pkg::PH_ADDR1; // RL17
         bitn   <= fdf_s ? `IBPE_ZERO4 : `IBPE_BYTE_BITS;
         in_ack <= 1'b0;
         dir_tx <= fdf_s ? !rdir_s : 1'b1;                          // RL19
         hdr_rw <= rdir_s && (rs_mode || !xa_s);
         sh     <= xa_s ? {`IBPE_HDR10, sa_s[9:8], rdir_s && rs_mode} // RL15
                        : {sa_s[6:0], rdir_s};                        // RL13
      end
      else if (start_det && !mst_act)
      begin
         slv_act <= 1'b1;
         phase   <= fdf_s ? ibpe_pkg::PH_DATA : ibpe_pkg::PH_ADDR1;
         bitn    <= fdf_s ? `IBPE_ZERO4 : `IBPE_BYTE_BITS;
         in_ack  <= 1'b0;
         dir_tx  <= fdf_s && rdir_s;                                  // RL20
         addr_ok <= 1'b0;
      end
      else if (stop_det)
         slv_act <= 1'b0;
      else if (slot_go && wb)
      begin
         sh   <= next_sh;
         bitn <= (phase == ibpe_pkg::PH_DATA) ? word_len(wl_s) : `IBPE_BYTE_BITS; // RL11 RL23
      end
      else if (sample && in_ack)
      begin
         in_ack <= 1'b0;
         if (phase == ibpe_pkg::PH_ADDR1)
         begin
            if (!mst_act && !addr_ok)
               slv_act <= 1'b0;
            else if (xa_s && !hdr_rw)
               phase <= ibpe_pkg::PH_ADDR2;
            else
            begin
               phase  <= ibpe_pkg::PH_DATA;
               dir_tx <= mst_act ? !hdr_rw : hdr_rw; // RL19 RL20
            end
         end
         else if (phase == ibpe_pkg::PH_ADDR2)
         begin
            phase  <= ibpe_pkg::PH_DATA;
            dir_tx <= mst_act; // RL16
            if (!mst_act && !addr_ok)
               slv_act <= 1'b0;
         end
         else if (!mst_act && dir_tx && sda_s)
            slv_act <= 1'b0; // no acknowledge: slave transmitter lets go
      end
      else if (sample && bitn != `IBPE_ZERO4)
      begin
         sh   <= rx_byte;
         bitn <= 4'(bitn - 4'h1);
         if (bitn == 4'h1)
            in_ack <= 1'b1; // RL14
         if (!mst_act && phase == ibpe_pkg::PH_ADDR1 && bitn == 4'h1)
         begin
            hdr_rw  <= rx_byte[0];
            addr_ok <= xa_s ? (rx_byte[7:1] == {`IBPE_HDR10, own_s[9:8]})
                            : (rx_byte[7:1] == own_s[6:0]);
         end
         if (!mst_act && phase == ibpe_pkg::PH_ADDR2 && bitn == 4'h1)
            addr_ok <= addr_ok && (rx_byte == own_s[7:0]);
      end
   end

   // open-drain data pin: enable means pull low, value is always zero
   always_ff @(posedge module_clk_in)
   begin
      if (!lrst_n)
      begin
         sda_oe_out <= 1'b0;
         sda_out    <= 1'b0; // RL1
      end
      else if (m_go_start || m_r2_end)
         sda_oe_out <= 1'b1; // RL5
      else if (m_p2_end || m_to_rs)
         sda_oe_out <= 1'b0; // RL6 RL10
      else if (m_to_stop)
         sda_oe_out <= 1'b1;
      else if (!mst_act && !slv_act)
         sda_oe_out <= 1'b0; // RL2
      else if (slot_go)
      begin
         // only ever changed in a low slot
         if (in_ack)
            sda_oe_out <= ack_drv;              // RL4 RL14
         else if (cur_tx)
            sda_oe_out <= !next_sh[7];          // RL4 RL12
         else
            sda_oe_out <= 1'b0;
      end
   end

   // slave slot tracking and clock pin; slave only ever stretches
   always_ff @(posedge module_clk_in)
   begin
      if (!lrst_n)
      begin
         slv_pend   <= 1'b0;
         scl_oe_out <= 1'b0;
         scl_out    <= 1'b0; // RL1
      end
      else
      begin
         if (slv_act && fall)
            slv_pend <= 1'b1;
         else if (slot_go || !slv_act)
            slv_pend <= 1'b0;
         scl_oe_out <= scl_m || (slv_pend && stall); // RL21
      end
   end

   // handshakes with the host: takes, puts, request echoes
   always_ff @(posedge module_clk_in)
   begin
      if (!lrst_n)
      begin
         take_t      <= 1'b0;
         take_wait   <= 1'b0;
         put_t       <= 1'b0;
         rx_hold     <= `IBPE_ZERO8;
         rx_pend     <= 1'b0;
         rd_p        <= 1'b0;
         start_ack_t <= 1'b0;
         stt_wait    <= 1'b0;
         stop_ack_t  <= 1'b0;
         stp_wait    <= 1'b0;
      end
      else
      begin
         rd_p <= rd_s;
         if (slot_go && wb && phase == ibpe_pkg::PH_DATA && dir_tx)
         begin
            take_t    <= ~take_t;
            take_wait <= 1'b1;
         end
         else if (!txf_s)
            take_wait <= 1'b0;
         // a word arriving wins over a read echo in the same cycle
         if (sample && !in_ack && bitn == 4'h1 && phase == ibpe_pkg::PH_DATA && !dir_tx)
         begin
            rx_hold <= rx_byte;
            put_t   <= ~put_t;
            rx_pend <= 1'b1;
         end
         else if (rd_s != rd_p)
            rx_pend <= 1'b0;
         if (m_go_start || m_to_rs)
         begin
            start_ack_t <= ~start_ack_t;
            stt_wait    <= 1'b1;
         end
         else if (!stt_s)
            stt_wait <= 1'b0;
         if (m_to_stop)
         begin
            stop_ack_t <= ~stop_ack_t;
            stp_wait   <= 1'b1;
         end
         else if (!stp_s)
            stp_wait <= 1'b0;
      end
   end
endmodule

// File: dv/ibpe_engine_sva.sv
// assertion checker for the engine's pins and status flags
`timescale 1ns/1ps
module ibpe_engine_chk (
   input wire logic module_clk_in,
   input wire logic resetn_in,
   input wire logic master_select_in,
   input wire logic sda_in,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic scl_out,
   input wire logic sda_oe_out,
   input wire logic scl_oe_out,
   input wire logic bus_busy_flag_out,
   input wire logic receive_shift_full_out,
   input wire logic master_mode_out,
   input wire logic transmitter_mode_out
);
   logic [7:0] hold_cnt;
   // *****
   // helpers
   // *****
   // time spent as master with an unread word; the ack bit may still run early on
   always_ff @(posedge module_clk_in)
   begin
      if (!resetn_in || !(receive_shift_full_out && master_mode_out))
         hold_cnt <= 8'h00;
      else if (hold_cnt != 8'hff)
         hold_cnt <= hold_cnt + 8'h01;
   end
   default clocking cb @(posedge module_clk_in); endclocking
   default disable iff (!resetn_in);
   // *****
   // assertions
   // *****
   chk_pins_open_drain: assert property (sda_out == 1'b0 && scl_out == 1'b0)
      else $error("pin driven high");
   chk_idle_release: assert property (!master_select_in && !bus_busy_flag_out
      |-> !sda_oe_out && !scl_oe_out) else $error("line held on idle bus");
   chk_start_busy: assert property ($rose(sda_oe_out) && scl_in
      |-> ##[1:60] bus_busy_flag_out) else $error("start without busy");
   chk_stop_scl_high: assert property ($fell(sda_oe_out) && scl_in
      |-> !scl_oe_out && $past(scl_in, 4)) else $error("bad stop");
   chk_sda_stable: assert property ($changed(sda_oe_out) && scl_in && $past(scl_in)
      |=> !scl_oe_out [*8]) else $error("data moved in clock high");
   chk_busy_clear: assert property ($rose(sda_in) && scl_in && $past(scl_in)
      |-> ##[1:60] !bus_busy_flag_out) else $error("busy after stop");
   chk_rx_hold: assert property (hold_cnt > 8'h64 |-> scl_oe_out)
      else $error("clock runs with unread word");
   chk_rx_dir: assert property ($rose(receive_shift_full_out)
      |-> master_mode_out && !transmitter_mode_out) else $error("bad receive mode");
   cov_start: cover property ($rose(bus_busy_flag_out));
   cov_hold: cover property (hold_cnt == 8'h80);
   cov_read: cover property ($rose(receive_shift_full_out));
endmodule
bind ibpe_engine ibpe_engine_chk ibpe_engine_chk_inst (.*);

// File: dv/ibpe_peer.sv
// behavioural bus slave answering the engine on the shared lines
`timescale 1ns/1ps
module ibpe_peer (
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic [3:0] len_in,
   input  wire logic       ff_in,
   input  wire logic [7:0] rd_in,
   output logic            sda_oe_out
);
   logic [7:0] q[$];
   logic [7:0] sh;
   logic       adr;
   logic       rd;
   int         n;
   int         w;
   initial
   begin
      n = 0;
      w = 8;
      adr = 1;
      rd = 0;
      sh = 8'h00;
      sda_oe_out = 0;
   end
   // start or stop restarts framing; free format has no address byte
   always @(sda_in)
   begin
      if (scl_in)
      begin
         n = 0;
         adr = !ff_in;
         rd = 0;
         sda_oe_out = 0;
      end
   end
   // sample on the rising clock, first bit is the most significant
   always @(posedge scl_in)
   begin
      w = adr ? 8 : int'(len_in);
      if (n < w)
         sh = (n == 0) ? {7'h00, sda_in} : {sh[6:0], sda_in};
      n = n + 1;
   end
   // only pulls low, and only while the clock is low
   always @(negedge scl_in)
   begin
      if (n == w + 1)
      begin
         n = 0;
         adr = 0;
      end
      w = adr ? 8 : int'(len_in);
      if (n == w)
         q.push_back(sh);
      if (n == w && (adr || !rd))
         sda_oe_out = 1;
      else if (rd && !adr && n < w)
         sda_oe_out = ~rd_in[w - 1 - n];
      else
         sda_oe_out = 0;
      if (n == w && adr)
         rd = sh[0];
   end
endmodule

// File: dv/testbench.sv
// self-checking bench for the two-wire bus protocol engine
`timescale 1ns/1ps
module testbench;
   logic       ref_clk_in = 0, module_clk_in = 0, resetn_in = 0, peer_oe;
   logic       master_select_in = 0, start_request_in = 0, stop_request_in = 0;
   logic       extended_address_select_in = 0, free_format_select_in = 0, read_dir_in = 0;
   logic       tx_write_in = 0, rx_read_in = 0, sda_in, scl_in;
   logic [2:0] word_length_field_in = 3'h0;
   logic [3:0] plen = 4'h8;
   logic [9:0] slave_address_in = 10'h05a, own_address_in = 10'h077;
   logic [7:0] tx_data_in = 8'hc3, rx_data_out;
   logic       sda_out, sda_oe_out, scl_out, scl_oe_out, bus_busy_flag_out;
   logic       receive_shift_full_out, transmit_shift_empty_n_out;
   logic       master_mode_out, transmitter_mode_out;
   int         error_cnt = 0, check_count = 0;
   // open-drain wires with pull-ups
   assign sda_in = ~(sda_oe_out | peer_oe);
   assign scl_in = ~scl_oe_out;
   ibpe_engine #(.QTR(8'h08)) ibpe_engine_inst (.*);
   ibpe_peer ibpe_peer_inst (.scl_in(scl_in), .sda_in(sda_in), .len_in(plen),
      .ff_in(free_format_select_in), .rd_in(8'hb5), .sda_oe_out(peer_oe));
   // host and link clocks, unrelated in phase
   initial
   begin
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   initial
   begin
      #3;
      forever #6 module_clk_in = ~module_clk_in;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // bounded wait: 0 busy, 1 rx full, 2 tx taken, k>2 peer holds k-2 words
   task automatic wait_on(input int k, input logic v);
      int i;
      for (i = 0; i < 5000; i++)
      begin
         if ((k == 0 ? bus_busy_flag_out : k == 1 ? receive_shift_full_out :
              k == 2 ? !transmit_shift_empty_n_out : ibpe_peer_inst.q.size() >= k - 2) === v)
            break;
         @(posedge ref_clk_in);
      end
      if (i == 5000)
      begin
         error_cnt++;
         test_done();
      end
   endtask
   // one-cycle host pulse: 0 start, 1 stop, 2 tx write, 3 rx read
   task automatic pulse(input int k);
      @(posedge ref_clk_in);
      start_request_in <= (k == 0);
      stop_request_in <= (k == 1);
      tx_write_in <= (k == 2);
      rx_read_in <= (k == 3);
      @(posedge ref_clk_in);
      {start_request_in, stop_request_in, tx_write_in, rx_read_in} <= 4'h0;
   endtask
   // main sequence: 7-bit write, short read, 10-bit restart, free format
   initial
   begin
      repeat (4) @(posedge ref_clk_in);
      resetn_in <= 1;
      repeat (4) @(posedge ref_clk_in);
      pulse(2);
      pulse(0);
      repeat (60) @(posedge ref_clk_in);
      chk(bus_busy_flag_out, 8'h00);
      master_select_in <= 1;
      wait_on(0, 1);
      wait_on(4, 1);
      chk(transmitter_mode_out, 8'h01);
      pulse(1);
      wait_on(0, 0);
      chk(ibpe_peer_inst.q[0], 8'hb4);
      chk(ibpe_peer_inst.q[1], 8'hc3);
      ibpe_peer_inst.q.delete();
      word_length_field_in <= 3'h3;
      plen <= 4'h3;
      read_dir_in <= 1;
      slave_address_in <= 10'h021;
      pulse(0);
      wait_on(1, 1);
      repeat (100) @(posedge ref_clk_in);
      chk(scl_oe_out, 8'h01);
      chk(rx_data_out & 8'h07, 8'h05);
      chk(ibpe_peer_inst.q[0], 8'h43);
      pulse(1);
      pulse(3);
      wait_on(0, 0);
      chk(receive_shift_full_out, 8'h00);
      ibpe_peer_inst.q.delete();
      word_length_field_in <= 3'h0;
      plen <= 4'h8;
      read_dir_in <= 0;
      extended_address_select_in <= 1;
      slave_address_in <= 10'h2a7;
      tx_data_in <= 8'h3c;
      pulse(2);
      pulse(0);
      wait_on(5, 1);
      read_dir_in <= 1;
      pulse(0);
      wait_on(1, 1);
      chk(bus_busy_flag_out, 8'h01);
      chk(rx_data_out, 8'hb5);
      chk(ibpe_peer_inst.q[0], 8'hf4);
      chk(ibpe_peer_inst.q[1], 8'ha7);
      chk(ibpe_peer_inst.q[2], 8'h3c);
      chk(ibpe_peer_inst.q[3], 8'hf5);
      pulse(1);
      pulse(3);
      wait_on(0, 0);
      ibpe_peer_inst.q.delete();
      extended_address_select_in <= 0;
      free_format_select_in <= 1;
      read_dir_in <= 0;
      word_length_field_in <= 3'h5;
      plen <= 4'h5;
      tx_data_in <= 8'h16;
      pulse(2);
      pulse(0);
      wait_on(3, 1);
      pulse(1);
      wait_on(0, 0);
      chk(ibpe_peer_inst.q[0], 8'h16);
      test_done();
   end
endmodule
